// ---- hdl/eirqf_top.sv ----
// external interrupt front end: control register, filters, edge select, latches
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - five external inputs, each noise filtered before edge detection
// - control bit 6: 0 shared pin is port bit, 1 it is input a
// - after reset the shared pin is a port, not an interrupt input
// - inputs a and e see falling edges only; reject below 2, accept 7 fast periods
// - input b rejects below 15 or 63 fast periods as selected
// - input b accepts 49 or 193 fast periods and longer
// - control bit 7: 0 rejects below 63, 1 below 15 fast periods
// - inputs c and d reject below 7, accept 25 fast periods
// - slow modes: all reject below 1, accept 3.5 slow periods
// - bits 1..3 pick edge of b..d: 0 rising, 1 falling
// - edge sets latch only with master and own enable plus source conditions
// - shared pin in port mode never sets latch a
// - clean edge reaches the latch within filter time plus three fast periods
// - filter width change on input b applies within 26 fast periods
// - source select routes input d or timer event onto latch d
module eirqf_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // interrupt pins, bit order a..e
  input wire logic [eirqf_pkg::NUM_IRQ-1:0] ext_irq_pin,
  // system clock mode, high in slow or sleep
  input wire logic slow_mode,
  // control register access
  input wire logic [eirqf_pkg::SFR_ADDR_W-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // cpu side enables and source selects
  input wire eirqf_pkg::eirqf_enable_t irq_enable_register,
  input wire eirqf_pkg::eirqf_src_sel_t src_sel,
  input wire logic timer_event_d,
  input wire logic timer_event_e,
  input wire logic [eirqf_pkg::NUM_IRQ-1:0] latch_clear,
  // results
  output logic [eirqf_pkg::NUM_IRQ-1:0] irq_latch,
  output logic shared_pin_irq_select
);
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [eirqf_pkg::NUM_IRQ-1:0] latch_ff, nxt_latch, set_req, src_ok, edge_hit, want_fall;
  logic [eirqf_pkg::NUM_IRQ-1:0] filt_level, filt_rise, filt_fall;
  logic [eirqf_pkg::FILT_CNT_W-1:0] fast_thr [eirqf_pkg::NUM_IRQ];
  logic [eirqf_pkg::SLOW_DIV_W-1:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic ctrl_wr, ctrl_rd;
  logic irq_b_filter_width_select;
  logic master;

  // control register
  always_comb begin
    ctrl_wr = sfr_wr && (sfr_addr == eirqf_pkg::CTRL_ADDR);
    ctrl_rd = sfr_rd && (sfr_addr == eirqf_pkg::CTRL_ADDR);
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl = sfr_wdata & eirqf_pkg::CTRL_RW_MASK;
    end
    // unused bits and other addresses read as zero
    nxt_rdata = 8'h00;
    if (ctrl_rd) begin
      nxt_rdata = ctrl_ff & eirqf_pkg::CTRL_RW_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= eirqf_pkg::CTRL_RESET;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign shared_pin_irq_select = ctrl_ff[eirqf_pkg::BIT_SHARED_SEL];
  assign irq_b_filter_width_select = ctrl_ff[eirqf_pkg::BIT_B_FILT_SEL];
  assign sfr_rdata = rdata_ff;

  // slow clock enable
  always_comb begin
    nxt_div = div_ff + 11'h001;
    nxt_tick = 1'b0;
    if (div_ff == eirqf_pkg::SLOW_DIV_LAST) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // per source widths and edges
  always_comb begin
    fast_thr[eirqf_pkg::IRQ_A] = eirqf_pkg::THR_AE;
    fast_thr[eirqf_pkg::IRQ_E] = eirqf_pkg::THR_AE;
    fast_thr[eirqf_pkg::IRQ_B] = irq_b_filter_width_select ?
      eirqf_pkg::THR_B_SHORT : eirqf_pkg::THR_B_LONG;
    fast_thr[eirqf_pkg::IRQ_C] = eirqf_pkg::THR_CD;
    fast_thr[eirqf_pkg::IRQ_D] = eirqf_pkg::THR_CD;
    want_fall[eirqf_pkg::IRQ_A] = 1'b1;
    want_fall[eirqf_pkg::IRQ_E] = 1'b1;
    want_fall[eirqf_pkg::IRQ_B] = ctrl_ff[eirqf_pkg::BIT_B_EDGE];
    want_fall[eirqf_pkg::IRQ_C] = ctrl_ff[eirqf_pkg::BIT_C_EDGE];
    want_fall[eirqf_pkg::IRQ_D] = ctrl_ff[eirqf_pkg::BIT_D_EDGE];
  end

  // enable conditions
  always_comb begin
    master = irq_enable_register.master_irq_enable;
    src_ok[eirqf_pkg::IRQ_A] = master && irq_enable_register.irq_a_enable
      && shared_pin_irq_select;
    src_ok[eirqf_pkg::IRQ_B] = master && irq_enable_register.irq_b_enable;
    src_ok[eirqf_pkg::IRQ_C] = master && irq_enable_register.irq_c_enable;
    src_ok[eirqf_pkg::IRQ_D] = master && irq_enable_register.irq_d_enable
      && !src_sel.irq_d_source_select;
    src_ok[eirqf_pkg::IRQ_E] = master && irq_enable_register.irq_e_enable
      && !src_sel.irq_e_source_select;
  end

  genvar gi;
  generate
    for (gi = 0; gi < eirqf_pkg::NUM_IRQ; gi++) begin : g_src
      eirqf_filter u_filter (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pin_in(ext_irq_pin[gi]),
        .slow_mode(slow_mode),
        .slow_tick(tick_ff),
        .fast_thr(fast_thr[gi]),
        .filt_level(filt_level[gi]),
        .rise_pulse(filt_rise[gi]),
        .fall_pulse(filt_fall[gi])
      );
      assign edge_hit[gi] = want_fall[gi] ? filt_fall[gi] : filt_rise[gi];
      assign set_req[gi] = edge_hit[gi] && src_ok[gi];
    end
  endgenerate

  // latches: a set in the clearing cycle wins
  always_comb begin
    nxt_latch = set_req | (latch_ff & ~latch_clear);
    if (src_sel.irq_d_source_select && timer_event_d && master
        && irq_enable_register.irq_d_enable) begin
      nxt_latch[eirqf_pkg::IRQ_D] = 1'b1;
    end
    if (src_sel.irq_e_source_select && timer_event_e && master
        && irq_enable_register.irq_e_enable) begin
      nxt_latch[eirqf_pkg::IRQ_E] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_ff <= '0;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  assign irq_latch = latch_ff;

  // helper state for the checks below
  logic ctrl_written_ff;
  logic [3:0] fast_run_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_written_ff <= 1'b0;
      fast_run_ff <= 4'h0;
    end else begin
      ctrl_written_ff <= ctrl_written_ff || ctrl_wr;
      if (slow_mode) begin
        fast_run_ff <= 4'h0;
      end else if (fast_run_ff != 4'hF) begin
        fast_run_ff <= fast_run_ff + 4'h1;
      end
    end
  end

  property p_reset_port;
    @(posedge ref_clk) disable iff (!reset_n)
    !ctrl_written_ff |-> !shared_pin_irq_select;
  endproperty
  a_reset_port: assert property (p_reset_port)
    else $error("shared pin left port mode without a register write");

  property p_a_needs_select;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(irq_latch[eirqf_pkg::IRQ_A]) |->
      $past(shared_pin_irq_select && filt_fall[eirqf_pkg::IRQ_A] && master);
  endproperty
  a_a_needs_select: assert property (p_a_needs_select)
    else $error("latch a set without interrupt pin function or falling edge");

  property p_ctrl_write_read;
    @(posedge ref_clk) disable iff (!reset_n)
    ctrl_wr ##1 ctrl_rd |=> (sfr_rdata == ($past(sfr_wdata, 2) & eirqf_pkg::CTRL_RW_MASK));
  endproperty
  a_ctrl_write_read: assert property (p_ctrl_write_read)
    else $error("control register read back differs from written value");

  property p_b_width_change;
    @(posedge ref_clk) disable iff (!reset_n)
    (ctrl_wr && sfr_wdata[eirqf_pkg::BIT_B_FILT_SEL]) |=> ##[0:25]
      (fast_thr[eirqf_pkg::IRQ_B] == eirqf_pkg::THR_B_SHORT);
  endproperty
  a_b_width_change: assert property (p_b_width_change)
    else $error("input b short filter width not applied in time");

  property p_c_fast_width;
    @(posedge ref_clk) disable iff (!reset_n)
    ($rose(filt_level[eirqf_pkg::IRQ_C]) && (fast_run_ff == 4'hF)) |->
      ($past(ext_irq_pin[eirqf_pkg::IRQ_C], 3) && $past(ext_irq_pin[eirqf_pkg::IRQ_C], 9));
  endproperty
  a_c_fast_width: assert property (p_c_fast_width)
    else $error("input c accepted a pulse shorter than seven periods");

  property p_b_rising;
    @(posedge ref_clk) disable iff (!reset_n)
    (!ctrl_ff[eirqf_pkg::BIT_B_EDGE] && filt_rise[eirqf_pkg::IRQ_B]
      && src_ok[eirqf_pkg::IRQ_B]) |=> irq_latch[eirqf_pkg::IRQ_B];
  endproperty
  a_b_rising: assert property (p_b_rising)
    else $error("rising edge on input b did not set its latch");

  property p_c_enable;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(irq_latch[eirqf_pkg::IRQ_C]) |->
      $past(master && irq_enable_register.irq_c_enable);
  endproperty
  a_c_enable: assert property (p_c_enable)
    else $error("latch c set while disabled");

  property p_e_falling_only;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(irq_latch[eirqf_pkg::IRQ_E]) |->
      $past(filt_fall[eirqf_pkg::IRQ_E] || (timer_event_e && src_sel.irq_e_source_select));
  endproperty
  a_e_falling_only: assert property (p_e_falling_only)
    else $error("latch e set without falling edge or timer event");

  property p_timer_route;
    @(posedge ref_clk) disable iff (!reset_n)
    (src_sel.irq_d_source_select && timer_event_d && master
      && irq_enable_register.irq_d_enable) |=> irq_latch[eirqf_pkg::IRQ_D];
  endproperty
  a_timer_route: assert property (p_timer_route)
    else $error("timer event did not set latch d");

  property p_set_beats_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    (set_req[eirqf_pkg::IRQ_C] && latch_clear[eirqf_pkg::IRQ_C]) |=>
      irq_latch[eirqf_pkg::IRQ_C] [*1];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("clear beat a simultaneous set on latch c");

  property p_pin_to_latch;
    @(posedge ref_clk) disable iff (!reset_n)
    ($fell(ext_irq_pin[eirqf_pkg::IRQ_A]) && filt_level[eirqf_pkg::IRQ_A])
      ##1 !ext_irq_pin[eirqf_pkg::IRQ_A] [*6]
      ##0 (fast_run_ff == 4'hF) ##0 src_ok[eirqf_pkg::IRQ_A]
      |-> ##[0:3] irq_latch[eirqf_pkg::IRQ_A];
  endproperty
  a_pin_to_latch: assert property (p_pin_to_latch)
    else $error("clean falling edge on input a did not reach the latch");

  c_latch_a: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(irq_latch[eirqf_pkg::IRQ_A]));
  c_slow_b: cover property (@(posedge ref_clk) disable iff (!reset_n)
    slow_mode && $rose(irq_latch[eirqf_pkg::IRQ_B]));
  c_timer_d: cover property (@(posedge ref_clk) disable iff (!reset_n)
    src_sel.irq_d_source_select && $rose(irq_latch[eirqf_pkg::IRQ_D]));
  c_set_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
    |(set_req & latch_clear));
endmodule // eirqf_top
`default_nettype wire

// ---- common/eirqf_pkg.sv ----
// constants and types shared by the external interrupt input filter
`default_nettype none
package eirqf_pkg;
  // clocking: the fast clock is the reference clock itself
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int FAST_CLK_HZ = 50_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int FC_CYCLES = REF_CLK_HZ / FAST_CLK_HZ;
  localparam int SLOW_DIV = REF_CLK_HZ / SLOW_CLK_HZ;
  localparam int SLOW_DIV_W = 11;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST = SLOW_DIV_W'(SLOW_DIV - 1);

  // sources, index order a..e
  localparam int NUM_IRQ = 5;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_C = 2;
  localparam int IRQ_D = 3;
  localparam int IRQ_E = 4;

  // noise rejection widths in fast clock periods
  localparam int FILT_CNT_W = 8;
  localparam int REJ_AE_FC = 2;
  localparam int REJ_B_SHORT_FC = 15;
  localparam int REJ_B_LONG_FC = 63;
  localparam int REJ_CD_FC = 7;
  localparam logic [FILT_CNT_W-1:0] THR_AE = FILT_CNT_W'(REJ_AE_FC * FC_CYCLES);
  localparam logic [FILT_CNT_W-1:0] THR_B_SHORT = FILT_CNT_W'(REJ_B_SHORT_FC * FC_CYCLES);
  localparam logic [FILT_CNT_W-1:0] THR_B_LONG = FILT_CNT_W'(REJ_B_LONG_FC * FC_CYCLES);
  localparam logic [FILT_CNT_W-1:0] THR_CD = FILT_CNT_W'(REJ_CD_FC * FC_CYCLES);
  // slow mode: level must hold across this many slow ticks
  localparam logic [FILT_CNT_W-1:0] THR_SLOW = 8'h02;
  localparam logic FILT_RESET_LVL = 1'b1;

  // control register
  localparam int SFR_ADDR_W = 6;
  localparam logic [SFR_ADDR_W-1:0] CTRL_ADDR = 6'h37;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'hCE;
  localparam int BIT_B_FILT_SEL = 7;
  localparam int BIT_SHARED_SEL = 6;
  localparam int BIT_D_EDGE = 3;
  localparam int BIT_C_EDGE = 2;
  localparam int BIT_B_EDGE = 1;

  typedef struct packed {
    logic master_irq_enable;
    logic irq_e_enable;
    logic irq_d_enable;
    logic irq_c_enable;
    logic irq_b_enable;
    logic irq_a_enable;
  } eirqf_enable_t;

  typedef struct packed {
    logic irq_e_source_select;
    logic irq_d_source_select;
  } eirqf_src_sel_t;
endpackage
`default_nettype wire

// ---- hdl/eirqf_filter.sv ----
// one pin: two-stage synchroniser, noise filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module eirqf_filter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pin and mode
  input wire logic pin_in,
  input wire logic slow_mode,
  input wire logic slow_tick,
  input wire logic [eirqf_pkg::FILT_CNT_W-1:0] fast_thr,
  // filtered result
  output logic filt_level,
  output logic rise_pulse,
  output logic fall_pulse
);
  logic sync1_ff, sync2_ff, lvl_ff, rise_ff, fall_ff;
  logic nxt_sync1, nxt_sync2, nxt_lvl, nxt_rise, nxt_fall;
  logic [eirqf_pkg::FILT_CNT_W-1:0] cnt_ff, nxt_cnt, cnt_inc, thr;
  logic advance;

  always_comb begin
    nxt_sync1 = pin_in;
    nxt_sync2 = sync1_ff;
    thr = slow_mode ? eirqf_pkg::THR_SLOW : fast_thr;
    advance = !slow_mode || slow_tick;
    cnt_inc = cnt_ff + 8'h01;
    nxt_cnt = cnt_ff;
    nxt_lvl = lvl_ff;
    nxt_rise = 1'b0;
    nxt_fall = 1'b0;
    if (sync2_ff == lvl_ff) begin
      nxt_cnt = '0;
    end else if (advance) begin
      // new level accepted once it has held for thr steps
      if (cnt_inc >= thr) begin
        nxt_lvl = sync2_ff;
        nxt_cnt = '0;
        nxt_rise = sync2_ff;
        nxt_fall = !sync2_ff;
      end else begin
        nxt_cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= eirqf_pkg::FILT_RESET_LVL;
      sync2_ff <= eirqf_pkg::FILT_RESET_LVL;
      lvl_ff <= eirqf_pkg::FILT_RESET_LVL;
      cnt_ff <= '0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      lvl_ff <= nxt_lvl;
      cnt_ff <= nxt_cnt;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign filt_level = lvl_ff;
  assign rise_pulse = rise_ff;
  assign fall_pulse = fall_ff;

  property p_sync_delay;
    @(posedge ref_clk) disable iff (!reset_n)
    $past(reset_n, 2) |-> (sync2_ff == $past(pin_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser output is not the pin delayed by two cycles");

  property p_slow_needs_tick;
    @(posedge ref_clk) disable iff (!reset_n)
    ($changed(lvl_ff) && $past(slow_mode)) |-> $past(slow_tick);
  endproperty
  a_slow_needs_tick: assert property (p_slow_needs_tick)
    else $error("slow mode filter level moved without a slow tick");

  property p_fast_no_glitch;
    @(posedge ref_clk) disable iff (!reset_n)
    ($changed(lvl_ff) && $past(!slow_mode) && ($past(fast_thr) >= 8'h02))
      |-> ($past(sync2_ff, 2) == lvl_ff);
  endproperty
  a_fast_no_glitch: assert property (p_fast_no_glitch)
    else $error("single cycle pulse passed the fast filter");
endmodule // eirqf_filter
`default_nettype wire

// ---- verification/eirqf_pin_src.sv ----
// model of the outside sources that drive the five interrupt pins
`timescale 1ns/1ps
`default_nettype none
module eirqf_pin_src (
  // clock
  input wire logic ref_clk,
  // pins, idle high
  output logic [eirqf_pkg::NUM_IRQ-1:0] pin_out
);
  initial begin
    pin_out = '1;
  end

  // low pulse of whole clock periods; the shared pin is driven in port mode as well as in interrupt mode
  task automatic pulse(input int idx, input int width);
    @(posedge ref_clk);
    pin_out[idx] <= 1'b0;
    repeat (width) @(posedge ref_clk);
    pin_out[idx] <= 1'b1;
  endtask
endmodule // eirqf_pin_src
`default_nettype wire

// ---- verification/eirqf_top_tb.sv ----
// self-checking bench for the external interrupt front end
`timescale 1ns/1ps
`default_nettype none
module eirqf_top_tb;
  logic ref_clk;
  logic reset_n;
  logic slow_mode;
  logic sfr_wr;
  logic sfr_rd;
  logic timer_event_d;
  logic timer_event_e;
  logic [5:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [4:0] ext_irq_pin;
  logic [4:0] latch_clear;
  logic [4:0] irq_latch;
  logic shared_pin_irq_select;
  eirqf_pkg::eirqf_enable_t en;
  eirqf_pkg::eirqf_src_sel_t sel;
  int fails;
  int n_tests;
  int t_idx[14] = '{0, 0, 4, 4, 1, 1, 1, 1, 2, 2, 3, 3, 0, 4};
  int t_wid[14] = '{2, 1, 2, 1, 63, 62, 15, 14, 7, 6, 7, 6, 7, 7};
  logic [7:0] t_ctl[14] = '{8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'hCE, 8'hCE,
                            8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4E};
  logic t_exp[14] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                      1'b1, 1'b1};

  eirqf_pin_src src (
    .ref_clk(ref_clk),
    .pin_out(ext_irq_pin)
  );

  eirqf_top uut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ext_irq_pin(ext_irq_pin),
    .slow_mode(slow_mode),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .irq_enable_register(en),
    .src_sel(sel),
    .timer_event_d(timer_event_d),
    .timer_event_e(timer_event_e),
    .latch_clear(latch_clear),
    .irq_latch(irq_latch),
    .shared_pin_irq_select(shared_pin_irq_select)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    sfr_addr <= addr;
    sfr_wdata <= data;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  // read data stands for one cycle only, so it is taken mid-cycle after the read edge
  task automatic rd(input logic [5:0] addr, output logic [7:0] data);
    sfr_addr <= addr;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(negedge ref_clk);
    data = sfr_rdata;
  endtask

  task automatic clear_all();
    @(posedge ref_clk);
    latch_clear <= 5'h1F;
    @(posedge ref_clk);
    latch_clear <= 5'h00;
  endtask

  task automatic latch_is(input int idx, input logic exp);
    check("irq_latch", {7'h00, irq_latch[idx]}, {7'h00, exp});
  endtask

  // control rewrite, settle, pulse, then look at the latch
  task automatic try_pulse(input int idx, input logic [7:0] ctl, input int width, input logic exp);
    wr(eirqf_pkg::CTRL_ADDR, ctl);
    repeat (26) @(posedge ref_clk);
    clear_all();
    src.pulse(idx, width);
    repeat (80) @(posedge ref_clk);
    latch_is(idx, exp);
    clear_all();
  endtask

  task automatic timer_case(input int idx);
    @(posedge ref_clk);
    if (idx == 3) timer_event_d <= 1'b1;
    else timer_event_e <= 1'b1;
    @(posedge ref_clk);
    timer_event_d <= 1'b0;
    timer_event_e <= 1'b0;
    repeat (3) @(posedge ref_clk);
    latch_is(idx, 1'b1);
    clear_all();
  endtask

  initial begin
    logic [7:0] v;
    fails = 0;
    n_tests = 0;
    reset_n = 1'b0;
    slow_mode = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 6'h00;
    sfr_wdata = 8'h00;
    timer_event_d = 1'b0;
    timer_event_e = 1'b0;
    latch_clear = 5'h00;
    en = 6'h3F;
    sel = 2'h0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 check("select after reset", {7'h00, shared_pin_irq_select}, 8'h00);
    check("latches after reset", {3'h0, irq_latch}, 8'h00);
    rd(eirqf_pkg::CTRL_ADDR, v);
    check("control reset", v, eirqf_pkg::CTRL_RESET);
    // shared pin as port: long fall must not latch
    try_pulse(0, 8'h0E, 20, 1'b0);
    // pin function and control rewritten with interrupts masked
    en <= 6'h00;
    wr(eirqf_pkg::CTRL_ADDR, 8'hFF);
    rd(eirqf_pkg::CTRL_ADDR, v);
    check("control readback", v, 8'hCE);
    check("select set", {7'h00, shared_pin_irq_select}, 8'h01);
    wr(6'h36, 8'h00);
    rd(eirqf_pkg::CTRL_ADDR, v);
    check("control after other write", v, 8'hCE);
    rd(6'h36, v);
    check("unmapped read", v, 8'h00);
    clear_all();
    en <= 6'h3F;
    // width boundaries per source, all edges falling
    for (int i = 0; i < 14; i++) begin
      try_pulse(t_idx[i], t_ctl[i], t_wid[i], t_exp[i]);
    end
    // set and clear of latch c in the same cycle: set wins
    clear_all();
    fork
      src.pulse(2, 20);
      begin
        repeat (10) @(posedge ref_clk);
        latch_clear <= 5'h04;
        @(posedge ref_clk);
        latch_clear <= 5'h00;
      end
    join
    latch_is(2, 1'b1);
    clear_all();
    // rising edge select: fall ignored, rise latched
    for (int i = 1; i < 4; i++) begin
      wr(eirqf_pkg::CTRL_ADDR, 8'h40);
      clear_all();
      src.pulse(i, 100);
      repeat (3) @(posedge ref_clk);
      latch_is(i, 1'b0);
      repeat (80) @(posedge ref_clk);
      latch_is(i, 1'b1);
      clear_all();
    end
    // gating by master and source selects
    en <= 6'h1F;
    try_pulse(0, 8'h4E, 20, 1'b0);
    en <= 6'h3F;
    sel <= 2'h3;
    try_pulse(3, 8'h4E, 20, 1'b0);
    try_pulse(4, 8'h4E, 20, 1'b0);
    timer_case(3);
    timer_case(4);
    sel <= 2'h0;
    // slow mode, interrupts masked across the switch
    en <= 6'h00;
    slow_mode <= 1'b1;
    repeat (4000) @(posedge ref_clk);
    en <= 6'h3F;
    clear_all();
    try_pulse(0, 8'h4E, 1000, 1'b0);
    src.pulse(0, 5400);
    repeat (4700) @(posedge ref_clk);
    latch_is(0, 1'b1);
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
endmodule // eirqf_top_tb
`default_nettype wire
